// ### design/pit_pkg.sv
package pit_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int ADR_W = 8;
	localparam int SEL_W = 4;
	localparam int COUNT_W = 16;
	localparam int SCALE_W = 8;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ADR_COUNT = 8'h00;
	localparam logic [7:0] ADR_SCALE = 8'h04;
	localparam logic [7:0] ADR_PERIOD = 8'h08;
	localparam logic [7:0] ADR_CTRL = 8'h0C;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int IRQ_EXPIRE_BIT = 0;
	localparam int WORD_LSB = 2;
	localparam int BYTE_W = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [7:0] SCALE_RST = 8'h00;
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic RUN_RST = 1'b0;
	localparam logic IRQ_STATUS_RST = 1'b0;
	localparam logic IRQ_MASK_RST = 1'b0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage : pit_pkg

// ### design/pit_prescaler.sv
`timescale 1ns/1ns
`default_nettype none

module pit_prescaler #(
	parameter int SCALE_W = pit_pkg::SCALE_W
) (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [SCALE_W-1:0] scale_i,
	// Terminal event
	output logic tick_o
);

	typedef struct packed {
		logic [SCALE_W-1:0] cnt;
	} pit_pscl_state_t;

	pit_pscl_state_t s_reg;
	pit_pscl_state_t s_next;

	assign tick_o = run_i & ~restart_i & (s_reg.cnt == scale_i);

	always_comb
	begin
		s_next = s_reg;
		if (restart_i || tick_o || !run_i)
		begin
			s_next.cnt = '0;
		end
		else
		begin
			s_next.cnt = s_reg.cnt + SCALE_W'(1);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_reg <= '0;
		end
		else if (ce_i)
		begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_tick_restart: assert property (ce_i && tick_o |=> s_reg.cnt == '0)
		else $error("prescaler did not restart after terminal");
	a_count_advance: assert property (
		ce_i && run_i && !restart_i && !tick_o |=> s_reg.cnt == $past(s_reg.cnt) + SCALE_W'(1))
		else $error("prescaler did not advance by one between events");

endmodule : pit_prescaler

`default_nettype wire

// ### design/pit_timer.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - 16-bit down counter, software loadable and readable, decrements per prescaler event.
// - 8-bit prescale holds n-1; counter steps once every n clocks.
// - Counter at zero raises the timer interrupt request.
// - Counter at zero reloads from the 16-bit period register, recurring.
module pit_timer #(
	parameter int COUNT_W = pit_pkg::COUNT_W,
	parameter int SCALE_W = pit_pkg::SCALE_W
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pit_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [pit_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [pit_pkg::DATA_W-1:0] wb_dat_i,
	output logic [pit_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Interrupt
	output logic irq_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic [SCALE_W-1:0] scale;
		logic [COUNT_W-1:0] period;
		logic run;
		logic irq_status;
		logic irq_mask;
		logic ack;
		logic [pit_pkg::DATA_W-1:0] rdata;
	} pit_state_t;

	localparam pit_state_t STATE_RST = '{
		count: COUNT_W'(pit_pkg::COUNT_RST),
		scale: SCALE_W'(pit_pkg::SCALE_RST),
		period: COUNT_W'(pit_pkg::PERIOD_RST),
		run: pit_pkg::RUN_RST,
		irq_status: pit_pkg::IRQ_STATUS_RST,
		irq_mask: pit_pkg::IRQ_MASK_RST,
		ack: 1'b0,
		rdata: pit_pkg::RDATA_RST
	};

	pit_state_t s_reg;
	pit_state_t s_next;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic reg_hit(
		input logic [pit_pkg::ADR_W-1:0] adr,
		input logic [pit_pkg::ADR_W-1:0] off
	);
		reg_hit = adr[pit_pkg::ADR_W-1:pit_pkg::WORD_LSB] == off[pit_pkg::ADR_W-1:pit_pkg::WORD_LSB];
	endfunction : reg_hit

	function automatic logic [pit_pkg::DATA_W-1:0] merge_bytes(
		input logic [pit_pkg::DATA_W-1:0] old,
		input logic [pit_pkg::DATA_W-1:0] wdat,
		input logic [pit_pkg::SEL_W-1:0] sel
	);
		logic [pit_pkg::DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < pit_pkg::SEL_W; b++)
		begin
			if (sel[b])
			begin
				res[b*pit_pkg::BYTE_W +: pit_pkg::BYTE_W] = wdat[b*pit_pkg::BYTE_W +: pit_pkg::BYTE_W];
			end
		end
		merge_bytes = res;
	endfunction : merge_bytes

	// ----------------------------------------
	// Bus strobes
	// ----------------------------------------
	logic req;
	logic wr_now;
	logic rd_now;
	logic wr_count;
	logic wr_scale;
	logic tick;
	logic expire;
	logic [pit_pkg::DATA_W-1:0] rd_mux;

	assign req = wb_cyc_i & wb_stb_i;
	// Writes and read side effects land on the acknowledged edge
	assign wr_now = req & wb_we_i & s_reg.ack;
	assign rd_now = req & ~wb_we_i & s_reg.ack;
	assign wr_count = wr_now & reg_hit(wb_adr_i, pit_pkg::ADR_COUNT);
	assign wr_scale = wr_now & reg_hit(wb_adr_i, pit_pkg::ADR_SCALE);

	always_comb
	begin
		rd_mux = '0;
		if (reg_hit(wb_adr_i, pit_pkg::ADR_COUNT))
		begin
			rd_mux = pit_pkg::DATA_W'(s_reg.count);
		end
		else if (reg_hit(wb_adr_i, pit_pkg::ADR_SCALE))
		begin
			rd_mux = pit_pkg::DATA_W'(s_reg.scale);
		end
		else if (reg_hit(wb_adr_i, pit_pkg::ADR_PERIOD))
		begin
			rd_mux = pit_pkg::DATA_W'(s_reg.period);
		end
		else if (reg_hit(wb_adr_i, pit_pkg::ADR_CTRL))
		begin
			rd_mux[pit_pkg::CTRL_RUN_BIT] = s_reg.run;
		end
		else if (reg_hit(wb_adr_i, pit_pkg::ADR_IRQ_STATUS))
		begin
			rd_mux[pit_pkg::IRQ_EXPIRE_BIT] = s_reg.irq_status;
		end
		else if (reg_hit(wb_adr_i, pit_pkg::ADR_IRQ_MASK))
		begin
			rd_mux[pit_pkg::IRQ_EXPIRE_BIT] = s_reg.irq_mask;
		end
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	pit_prescaler #(
		.SCALE_W(SCALE_W)
	) u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.run_i(s_reg.run),
		.restart_i(wr_count | wr_scale),
		.scale_i(s_reg.scale),
		.tick_o(tick)
	);

	assign expire = tick & (s_reg.count == '0);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.ack = req & ~s_reg.ack;
		if (req && !s_reg.ack)
		begin
			s_next.rdata = rd_mux;
		end
		if (expire)
		begin
			s_next.count = s_reg.period;
		end
		else if (tick)
		begin
			s_next.count = s_reg.count - COUNT_W'(1);
		end
		if (wr_count)
		begin
			s_next.count = COUNT_W'(merge_bytes(pit_pkg::DATA_W'(s_reg.count), wb_dat_i, wb_sel_i));
		end
		if (wr_scale)
		begin
			s_next.scale = SCALE_W'(merge_bytes(pit_pkg::DATA_W'(s_reg.scale), wb_dat_i, wb_sel_i));
		end
		if (wr_now && reg_hit(wb_adr_i, pit_pkg::ADR_PERIOD))
		begin
			s_next.period = COUNT_W'(merge_bytes(pit_pkg::DATA_W'(s_reg.period), wb_dat_i, wb_sel_i));
		end
		if (wr_now && reg_hit(wb_adr_i, pit_pkg::ADR_CTRL) && wb_sel_i[0])
		begin
			s_next.run = wb_dat_i[pit_pkg::CTRL_RUN_BIT];
		end
		if (wr_now && reg_hit(wb_adr_i, pit_pkg::ADR_IRQ_MASK) && wb_sel_i[0])
		begin
			s_next.irq_mask = wb_dat_i[pit_pkg::IRQ_EXPIRE_BIT];
		end
		if (rd_now && reg_hit(wb_adr_i, pit_pkg::ADR_IRQ_STATUS))
		begin
			s_next.irq_status = 1'b0;
		end
		if (expire)
		begin
			s_next.irq_status = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_reg <= STATE_RST;
		end
		else if (ce_i)
		begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Ack only shown on an enabled edge, where the access really lands
	assign wb_ack_o = s_reg.ack & ce_i;
	assign wb_dat_o = s_reg.rdata;
	assign irq_o = s_reg.irq_status & s_reg.irq_mask;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence expiry_seq;
		ce_i && expire && !wr_count;
	endsequence

	sequence step_seq;
		ce_i && tick && !expire && !wr_count;
	endsequence

	a_count_step: assert property (step_seq |=> s_reg.count == $past(s_reg.count) - COUNT_W'(1))
		else $error("count did not step down by one");
	a_count_hold: assert property (ce_i && !tick && !wr_count |=> s_reg.count == $past(s_reg.count))
		else $error("count moved without a prescaler event");
	a_zero_irq: assert property (expiry_seq ##1 (s_reg.irq_mask && ce_i && !wr_now && !rd_now) |-> ##1 irq_o)
		else $error("expiry did not raise interrupt");
	a_status_set: assert property (ce_i && expire |=> s_reg.irq_status)
		else $error("expiry status not set");
	a_zero_reload: assert property (expiry_seq |=> s_reg.count == $past(s_reg.period))
		else $error("count not reloaded from period");
	a_scale_zero: assert property (ce_i && s_reg.run && s_reg.scale == '0 && !wr_count && !wr_scale |-> tick)
		else $error("zero prescale did not step every cycle");
	a_scale_gap: assert property (ce_i && tick && s_reg.scale != '0 |=> !tick)
		else $error("prescaler events too close");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule : pit_timer

`default_nettype wire

// ### tb/pit_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none

module pit_timer_tb;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	int n_mismatch = 0;
	int compares = 0;
	logic [7:0] adrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [7:0] wadr [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
	logic [31:0] wexp [5] = '{32'h0000_FFFF, 32'h0000_00FF, 32'h0000_FFFF, 32'h1, 32'h0};

	always #5 clk_i = ~clk_i;

	pit_timer u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.irq_o(irq_o)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask : check

	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (wb_ack_o !== 1'b1 && i < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (i >= 50)
		begin
			$display("MISMATCH bus ack expected 1 seen none");
			n_mismatch++;
			tally_and_finish();
		end
	endtask : wb_xfer

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] d;
		wb_xfer(1'b1, adr, dat, d);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		wb_xfer(1'b0, adr, 32'h0, d);
		check(what, exp, d);
	endtask : rd_chk

	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (irq_o !== 1'b1)
		begin
			@(posedge clk_i);
			n++;
			if (n > lim)
			begin
				$display("MISMATCH irq rise expected 1 seen 0");
				n_mismatch++;
				tally_and_finish();
			end
		end
	endtask : wait_irq

	// Expiry spacing, k cycles of frozen clock enable added
	task automatic interval(input logic [7:0] s, input logic [15:0] p, input int k);
		logic [31:0] d;
		longint t1;
		wr(8'h0C, 32'h0);
		wr(8'h04, {24'h0, s});
		wr(8'h08, {16'h0, p});
		wr(8'h00, 32'h0);
		wr(8'h14, 32'h1);
		wb_xfer(1'b0, 8'h10, 32'h0, d);
		wr(8'h0C, 32'h1);
		wait_irq(2000);
		t1 = $time;
		rd_chk("expiry status", 8'h10, 32'h1);
		@(posedge clk_i);
		check("irq after clear", 32'h0, {31'h0, irq_o});
		if (k > 0)
		begin
			ce_i <= 1'b0;
			repeat (k) @(posedge clk_i);
			ce_i <= 1'b1;
		end
		wait_irq(2000);
		check("expiry interval", (32'(p) + 1) * (32'(s) + 1) + k, 32'(($time - t1) / 10));
		$display("interval test scale %0d period %0d done", s, p);
	endtask : interval

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			rd_chk("reset value", adrs[i], 32'h0);
		end
		$display("reset value test done");
		for (int i = 0; i < 5; i++)
		begin
			wr(wadr[i], 32'hFFFF_FFFF);
			rd_chk("register width", wadr[i], wexp[i]);
		end
		wr(8'h00, 32'h0000_1234);
		repeat (20) @(posedge clk_i);
		rd_chk("count held", 8'h00, 32'h0000_1234);
		$display("register access test done");
		interval(8'h00, 16'h0004, 0);
		interval(8'hFF, 16'h0001, 0);
		interval(8'h02, 16'h0003, 7);
		wr(8'h14, 32'h0);
		wb_xfer(1'b0, 8'h10, 32'h0, d);
		repeat (30) @(posedge clk_i);
		check("masked irq", 32'h0, {31'h0, irq_o});
		wr(8'h14, 32'h1);
		@(posedge clk_i);
		check("unmasked irq", 32'h1, {31'h0, irq_o});
		$display("interrupt mask test done");
		tally_and_finish();
	end

endmodule : pit_timer_tb

`default_nettype wire
